// ==== pinit_pkg.sv ====
// Contract
// - Internal power-on reset stays active until the bias supply and core supply rail are good and the oscillator is stable.
// - On leaving reset a load cycle copies the rewritable config store into the working registers.
// - After the load the management bus may reconfigure the working registers whatever the enable input shows.
// - In the default mode conversion starts only with enable good, input bus good, load complete and address read.
// - The host-selectable software mode replaces the default pin-based enable condition; the pin-and-software mode requires both.
// - Separate 7-bit base addresses exist for I2C and PMBus, and a base of zero disables only that interface.
// - The stored base addresses default to 0x10 for I2C and 0x40 for PMBus and the strap offset is added to them.
// - During start-up the strap is measured by the 10-bit converter and one of 16 offsets is derived from it.
// - Rising strap resistance maps to offsets +0 to +15, and above 11250 ohms gives +15.
// - Once the address is known each interface answers only to its own computed address.
// - With the ignore-offset bit set both interfaces answer at their plain base addresses.
package pinit_pkg;
  localparam int ADC_W       = 10;
  localparam int ADDR_W      = 7;
  localparam int OFS_W       = 4;
  localparam int NUM_OFS     = 16;
  localparam int DATA_W      = 8;
  localparam int IDX_W       = 2;
  localparam int STORE_WORDS = 3;

  localparam logic [IDX_W-1:0] REG_I2C_BASE   = 2'h0;
  localparam logic [IDX_W-1:0] REG_PMBUS_BASE = 2'h1;
  localparam logic [IDX_W-1:0] REG_CTRL       = 2'h2;
  localparam logic [IDX_W-1:0] REG_STATUS     = 2'h3;

  localparam logic [ADDR_W-1:0] I2C_BASE_RST   = 7'h10;
  localparam logic [ADDR_W-1:0] PMBUS_BASE_RST = 7'h40;
  localparam logic [DATA_W-1:0] CTRL_RST       = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_MASK      = 8'h0F;

  localparam int CTRL_IGNORE_OFS = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_SW_ON      = 3;
  localparam logic [1:0] MODE_PIN        = 2'h0;
  localparam logic [1:0] MODE_SW         = 2'h1;
  localparam logic [1:0] MODE_PIN_AND_SW = 2'h2;

  localparam int STAT_LOADED   = 0;
  localparam int STAT_ADDR_RDY = 1;
  localparam int STAT_CONV     = 2;
  localparam int STAT_OFS_LSB  = 4;

  localparam int ADC_FS_OHM  = 16000;
  localparam int ADC_FS_CODE = 1023;
  localparam int STRAP_EDGE_OHM [0:NUM_OFS-2] = '{775, 1295, 1795, 2330, 2925, 3535, 4180, 4880,
                                                  5635, 6510, 7425, 8370, 9315, 10230, 11250};

  typedef enum logic [2:0] {
    st_por, st_load_req, st_load_wait, st_strap_req, st_strap_wait, st_addr_calc, st_ready
  } init_state_e;
endpackage

// ==== strap_if.sv ====
`timescale 1ns/1ps
interface strap_if;
  import pinit_pkg::*;
  logic [ADC_W-1:0] code;
  logic [OFS_W-1:0] offset;
  modport decoder (input code, output offset);
  modport user (output code, input offset);
endinterface

// ==== strap_offset_decoder.sv ====
`timescale 1ns/1ps
module strap_offset_decoder
  import pinit_pkg::*;
(
  strap_if.decoder s
);
  logic [NUM_OFS-2:0] above;
  logic [OFS_W-1:0]   cnt;

  // Each edge sits midway between two nominal strap resistors, so a part at tolerance still lands in its slot.
  for (genvar i = 0; i < NUM_OFS - 1; i++) begin : g_edge
    localparam logic [ADC_W-1:0] EDGE_CODE = ADC_W'(STRAP_EDGE_OHM[i] * ADC_FS_CODE / ADC_FS_OHM);
    assign above[i] = s.code > EDGE_CODE;
  end

  always_comb begin
    cnt = '0;
    for (int i = 0; i < NUM_OFS - 1; i++) begin
      cnt = cnt + OFS_W'(above[i]);
    end
  end

  assign s.offset = cnt;
endmodule

// ==== powerup_init_and_bus_address.sv ====
`timescale 1ns/1ps
module powerup_init_and_bus_address
  import pinit_pkg::*;
#(
  parameter int ADC_BITS = ADC_W
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              bias_ok_i,
  input  wire logic              core_supply_rail_ok_i,
  input  wire logic              osc_stable_i,
  input  wire logic              enable_ok_i,
  input  wire logic              input_bus_ok_i,
  output logic                   store_rd_o,
  output logic [IDX_W-1:0]       store_addr_o,
  input  wire logic [DATA_W-1:0] store_data_i,
  input  wire logic              store_valid_i,
  output logic                   adc_start_o,
  input  wire logic              adc_done_i,
  input  wire logic [ADC_W-1:0]  adc_code_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [IDX_W-1:0]  reg_idx_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0]      reg_rdata_o,
  output logic                   reg_ack_o,
  input  wire logic [ADDR_W-1:0] i2c_addr_i,
  input  wire logic              i2c_addr_vld_i,
  output logic                   i2c_match_o,
  input  wire logic [ADDR_W-1:0] pmbus_addr_i,
  input  wire logic              pmbus_addr_vld_i,
  output logic                   pmbus_match_o,
  output logic                   por_o,
  output logic                   config_loaded_o,
  output logic                   addr_ready_o,
  output logic                   convert_en_o
);
  if (ADC_BITS != ADC_W) begin : g_bad_adc
    $error("ADC_BITS must equal the converter width of the strap decoder");
  end

  // --------------------------------------------------------------------------
  // Start-up sequence and working registers
  // --------------------------------------------------------------------------
  init_state_e       state, next_state;
  logic [IDX_W-1:0]  idx, next_idx;
  logic [ADDR_W-1:0] i2c_base, next_i2c_base;
  logic [ADDR_W-1:0] pmbus_base, next_pmbus_base;
  logic [DATA_W-1:0] ctrl, next_ctrl;
  logic              loaded, next_loaded;
  logic              addr_rdy, next_addr_rdy;
  logic [ADC_W-1:0]  strap_code, next_strap_code;
  logic [OFS_W-1:0]  ofs, next_ofs;
  logic [ADDR_W-1:0] i2c_eff, next_i2c_eff;
  logic [ADDR_W-1:0] pmbus_eff, next_pmbus_eff;
  logic              i2c_on, next_i2c_on;
  logic              pmbus_on, next_pmbus_on;
  logic              conv, next_conv;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic              ack, next_ack;
  logic              por_hold;
  logic              wr_ok;
  logic [1:0]        mode;
  logic [ADDR_W:0]   i2c_sum;
  logic [ADDR_W:0]   pmbus_sum;
  logic [OFS_W-1:0]  ofs_used;

  strap_if strap ();
  assign strap.code = strap_code;

  strap_offset_decoder u_dec (
    .s (strap.decoder)
  );

  assign por_hold = !(bias_ok_i && core_supply_rail_ok_i && osc_stable_i);
  assign wr_ok    = loaded && reg_wr_i;
  assign mode     = ctrl[CTRL_MODE_LSB +: 2];
  assign ofs_used = ctrl[CTRL_IGNORE_OFS] ? '0 : strap.offset;
  assign i2c_sum   = {1'b0, i2c_base} + {{(ADDR_W + 1 - OFS_W){1'b0}}, ofs_used};
  assign pmbus_sum = {1'b0, pmbus_base} + {{(ADDR_W + 1 - OFS_W){1'b0}}, ofs_used};

  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_i2c_base   = i2c_base;
    next_pmbus_base = pmbus_base;
    next_ctrl       = ctrl;
    next_loaded     = loaded;
    next_addr_rdy   = addr_rdy;
    next_strap_code = strap_code;
    next_ofs        = ofs;
    next_i2c_eff    = i2c_eff;
    next_pmbus_eff  = pmbus_eff;
    next_i2c_on     = i2c_on;
    next_pmbus_on   = pmbus_on;
    next_ack        = 1'b0;
    next_rdata      = rdata;
    case (state)
      st_por: begin
        if (!por_hold) begin
          next_state = st_load_req;
          next_idx   = '0;
        end
      end
      st_load_req: begin
        next_state = st_load_wait;
      end
      st_load_wait: begin
        if (store_valid_i) begin
          case (idx)
            REG_I2C_BASE:   next_i2c_base   = store_data_i[ADDR_W-1:0];
            REG_PMBUS_BASE: next_pmbus_base = store_data_i[ADDR_W-1:0];
            default:        next_ctrl       = store_data_i & CTRL_MASK;
          endcase
          if (idx == IDX_W'(STORE_WORDS - 1)) begin
            next_loaded = 1'b1;
            next_state  = st_strap_req;
          end else begin
            next_idx   = idx + 1'b1;
            next_state = st_load_req;
          end
        end
      end
      st_strap_req: begin
        next_state = st_strap_wait;
      end
      st_strap_wait: begin
        if (adc_done_i) begin
          next_strap_code = adc_code_i;
          next_state      = st_addr_calc;
        end
      end
      st_addr_calc: begin
        next_ofs       = strap.offset;
        next_i2c_eff   = i2c_sum[ADDR_W-1:0];
        next_pmbus_eff = pmbus_sum[ADDR_W-1:0];
        next_i2c_on    = i2c_base != '0;
        next_pmbus_on  = pmbus_base != '0;
        next_addr_rdy  = 1'b1;
        next_state     = st_ready;
      end
      st_ready: begin
      end
      default: begin
        next_state = st_por;
      end
    endcase
    // Host writes are refused until the load completes, so the store cannot overwrite a host value.
    if (wr_ok) begin
      next_ack = 1'b1;
      case (reg_idx_i)
        REG_I2C_BASE:   next_i2c_base   = reg_wdata_i[ADDR_W-1:0];
        REG_PMBUS_BASE: next_pmbus_base = reg_wdata_i[ADDR_W-1:0];
        REG_CTRL:       next_ctrl       = reg_wdata_i & CTRL_MASK;
        default:        next_ack        = 1'b1;
      endcase
    end else if (loaded && reg_rd_i) begin
      next_ack = 1'b1;
      case (reg_idx_i)
        REG_I2C_BASE:   next_rdata = {1'b0, i2c_base};
        REG_PMBUS_BASE: next_rdata = {1'b0, pmbus_base};
        REG_CTRL:       next_rdata = ctrl;
        default:        next_rdata = {ofs, 1'b0, conv, addr_rdy, loaded};
      endcase
    end
    if (por_hold) begin
      next_state      = st_por;
      next_idx        = '0;
      next_i2c_base   = I2C_BASE_RST;
      next_pmbus_base = PMBUS_BASE_RST;
      next_ctrl       = CTRL_RST;
      next_loaded     = 1'b0;
      next_addr_rdy   = 1'b0;
      next_ack        = 1'b0;
    end
  end

  // Conversion gate: the pin condition is the default, software mode replaces it, pin-and-software mode needs both.
  always_comb begin
    case (mode)
      MODE_SW:         next_conv = ctrl[CTRL_SW_ON];
      MODE_PIN_AND_SW: next_conv = ctrl[CTRL_SW_ON] && enable_ok_i;
      default:         next_conv = enable_ok_i;
    endcase
    next_conv = next_conv && input_bus_ok_i && loaded && addr_rdy && !por_hold;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state      <= st_por;
      idx        <= '0;
      i2c_base   <= I2C_BASE_RST;
      pmbus_base <= PMBUS_BASE_RST;
      ctrl       <= CTRL_RST;
      loaded     <= 1'b0;
      addr_rdy   <= 1'b0;
      strap_code <= '0;
      ofs        <= '0;
      i2c_eff    <= '0;
      pmbus_eff  <= '0;
      i2c_on     <= 1'b0;
      pmbus_on   <= 1'b0;
      conv       <= 1'b0;
      rdata      <= '0;
      ack        <= 1'b0;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      i2c_base   <= next_i2c_base;
      pmbus_base <= next_pmbus_base;
      ctrl       <= next_ctrl;
      loaded     <= next_loaded;
      addr_rdy   <= next_addr_rdy;
      strap_code <= next_strap_code;
      ofs        <= next_ofs;
      i2c_eff    <= next_i2c_eff;
      pmbus_eff  <= next_pmbus_eff;
      i2c_on     <= next_i2c_on;
      pmbus_on   <= next_pmbus_on;
      conv       <= next_conv;
      rdata      <= next_rdata;
      ack        <= next_ack;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign por_o           = state == st_por;
  assign store_rd_o      = state == st_load_req;
  assign store_addr_o    = idx;
  assign adc_start_o     = state == st_strap_req;
  assign config_loaded_o = loaded;
  assign addr_ready_o    = addr_rdy;
  assign convert_en_o    = conv;
  assign reg_rdata_o     = rdata;
  assign reg_ack_o       = ack;
  // A base written after start-up never moves the matched address; the next start-up reloads the store, keeping the address stable on the wire.
  assign i2c_match_o   = addr_rdy && i2c_on && i2c_addr_vld_i && (i2c_addr_i == i2c_eff);
  assign pmbus_match_o = addr_rdy && pmbus_on && pmbus_addr_vld_i && (pmbus_addr_i == pmbus_eff);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  localparam logic [ADC_W-1:0] TOP_EDGE_CODE = ADC_W'(STRAP_EDGE_OHM[NUM_OFS-2] * ADC_FS_CODE / ADC_FS_OHM);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_load_start;
    store_rd_o ##1 (state == st_load_wait);
  endsequence
  sequence s_strap_start;
    adc_start_o ##1 (state == st_strap_wait) && !adc_start_o;
  endsequence

  chk_por_hold: assert property (por_hold |=> por_o && !convert_en_o && !loaded)
    else $error("power-on reset released while supplies or oscillator not good");
  chk_load_start: assert property ((por_o && !por_hold) |=> s_load_start)
    else $error("load cycle did not start after reset release");
  chk_load_copy: assert property ((state == st_load_wait && store_valid_i && idx == REG_PMBUS_BASE && !por_hold)
                                  |=> pmbus_base == $past(store_data_i[ADDR_W-1:0]))
    else $error("store word not copied into working register");
  chk_host_write: assert property ((loaded && reg_wr_i && reg_idx_i == REG_I2C_BASE && !por_hold)
                                   |=> reg_ack_o && i2c_base == $past(reg_wdata_i[ADDR_W-1:0]))
    else $error("host write after load not accepted");
  chk_write_refused: assert property ((!loaded && reg_wr_i) |=> !reg_ack_o)
    else $error("host write accepted before load completed");
  chk_pin_gate: assert property ((mode == MODE_PIN && (!enable_ok_i || !input_bus_ok_i || !addr_rdy)) |=> !convert_en_o)
    else $error("conversion started without all default conditions");
  chk_sw_mode: assert property ((mode == MODE_SW && ctrl[CTRL_SW_ON] && input_bus_ok_i && addr_rdy && !por_hold)
                                |=> convert_en_o)
    else $error("software enable did not start conversion");
  chk_zero_base: assert property ((state == st_addr_calc && i2c_base == '0)
                                  |=> !i2c_on && (pmbus_on == ($past(pmbus_base) != '0)))
    else $error("zero base did not disable only its own interface");
  chk_default_base: assert property ((por_o && !por_hold) |-> i2c_base == I2C_BASE_RST && pmbus_base == PMBUS_BASE_RST)
    else $error("default base address wrong at reset release");
  chk_strap_start: assert property ((state == st_load_wait && store_valid_i && idx == IDX_W'(STORE_WORDS - 1) && !por_hold)
                                    |=> s_strap_start)
    else $error("strap measurement not started after load");
  chk_strap_top: assert property ((state == st_addr_calc && strap_code > TOP_EDGE_CODE && !por_hold)
                                  |=> ofs == 4'hF)
    else $error("highest strap range did not give the top offset");
  chk_addr_match: assert property (i2c_match_o |-> addr_rdy && i2c_addr_i == i2c_eff)
    else $error("I2C answered to a foreign address");
  chk_ignore_ofs: assert property ((state == st_addr_calc && ctrl[CTRL_IGNORE_OFS] && !por_hold)
                                   |=> i2c_eff == $past(i2c_base) && pmbus_eff == $past(pmbus_base))
    else $error("strap offset used while ignore bit set");
  chk_eff_latch: assert property ((state == st_ready && $past(state) == st_ready) |-> $stable(i2c_eff) && $stable(pmbus_eff))
    else $error("effective address changed after start-up");
endmodule

// ==== store_adc_model.sv ====
`timescale 1ns/1ps
module store_adc_model
  import pinit_pkg::*;
(
  input  wire logic                              mclk_i,
  input  wire logic                              sys_rst_i,
  input  wire logic                              store_rd_i,
  input  wire logic [IDX_W-1:0]                  store_addr_i,
  input  wire logic [STORE_WORDS-1:0][DATA_W-1:0] words_i,
  input  wire logic [3:0]                        lat_i,
  input  wire logic                              adc_start_i,
  input  wire logic [ADC_W-1:0]                  strap_code_i,
  output logic [DATA_W-1:0]                      store_data_o,
  output logic                                   store_valid_o,
  output logic                                   adc_done_o,
  output logic [ADC_W-1:0]                       adc_code_o
);
  logic [4:0]       st_cnt;
  logic [4:0]       adc_cnt;
  logic [IDX_W-1:0] word_idx;

  // ----------------------------------------
  // Delayed answers of store and converter
  // ----------------------------------------
  // A count of 5'h1F means idle. Released data lines flip every cycle, so a
  // design that samples outside the valid pulse sees garbage, not the last word.
  initial begin
    {store_valid_o, adc_done_o} = 2'h0;
    {store_data_o, adc_code_o}  = 18'h2A5A5;
  end
  always @(posedge mclk_i) begin
    store_valid_o <= 1'b0;
    adc_done_o    <= 1'b0;
    store_data_o  <= ~store_data_o;
    adc_code_o    <= ~adc_code_o;
    if (sys_rst_i) begin
      st_cnt  <= 5'h1F;
      adc_cnt <= 5'h1F;
    end else begin
      if (store_rd_i) begin
        st_cnt   <= {1'b0, lat_i};
        word_idx <= store_addr_i;
      end else if (st_cnt == 5'h00) begin
        store_valid_o <= 1'b1;
        store_data_o  <= words_i[word_idx];
        st_cnt        <= 5'h1F;
      end else if (st_cnt != 5'h1F) begin
        st_cnt <= st_cnt - 5'h01;
      end
      if (adc_start_i) begin
        adc_cnt <= {1'b0, lat_i};
      end else if (adc_cnt == 5'h00) begin
        adc_done_o <= 1'b1;
        adc_code_o <= strap_code_i;
        adc_cnt    <= 5'h1F;
      end else if (adc_cnt != 5'h1F) begin
        adc_cnt <= adc_cnt - 5'h01;
      end
    end
  end
endmodule

// ==== test_powerup_init_and_bus_address.sv ====
`timescale 1ns/1ps
module test_powerup_init_and_bus_address;
  import pinit_pkg::*;
  logic                               mclk_i, sys_rst_i, bias_ok_i, core_supply_rail_ok_i, osc_stable_i;
  logic                               enable_ok_i, input_bus_ok_i, store_rd_o, store_valid_i, adc_start_o, adc_done_i;
  logic                               reg_wr_i, reg_rd_i, reg_ack_o, i2c_addr_vld_i, i2c_match_o, pmbus_addr_vld_i;
  logic                               pmbus_match_o, por_o, config_loaded_o, addr_ready_o, convert_en_o;
  logic [IDX_W-1:0]                   store_addr_o, reg_idx_i;
  logic [DATA_W-1:0]                  store_data_i, reg_wdata_i, reg_rdata_o;
  logic [ADC_W-1:0]                   adc_code_i, strap_code;
  logic [ADDR_W-1:0]                  i2c_addr_i, pmbus_addr_i;
  logic [STORE_WORDS-1:0][DATA_W-1:0] words;
  logic [3:0]                         lat;
  logic [31:0]                        seed;
  int                                 n_fail = 0;
  int                                 checked = 0;

  powerup_init_and_bus_address dut_u (
    .mclk_i, .sys_rst_i, .bias_ok_i, .core_supply_rail_ok_i, .osc_stable_i, .enable_ok_i, .input_bus_ok_i,
    .store_rd_o, .store_addr_o, .store_data_i, .store_valid_i, .adc_start_o, .adc_done_i, .adc_code_i,
    .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .i2c_addr_i, .i2c_addr_vld_i,
    .i2c_match_o, .pmbus_addr_i, .pmbus_addr_vld_i, .pmbus_match_o, .por_o, .config_loaded_o, .addr_ready_o,
    .convert_en_o
  );
  store_adc_model far_u (
    .mclk_i, .sys_rst_i, .store_rd_i(store_rd_o), .store_addr_i(store_addr_o), .words_i(words), .lat_i(lat),
    .adc_start_i(adc_start_o), .strap_code_i(strap_code), .store_data_o(store_data_i),
    .store_valid_o(store_valid_i), .adc_done_o(adc_done_i), .adc_code_o(adc_code_i)
  );

  // ----------------------------------------
  // Reference model and bus tasks
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int ref_ofs(input int code);
    int n;
    n = 0;
    for (int e = 0; e < NUM_OFS - 1; e++) n += (code > STRAP_EDGE_OHM[e] * ADC_FS_CODE / ADC_FS_OHM);
    return n;
  endfunction
  function automatic int ref_conv(input int ctl, input int en, input int bus);
    return bus && (((ctl >> 1 & 3) == 1) ? (ctl >> 3 & 1) : ((ctl >> 1 & 3) == 2) ? en && (ctl >> 3 & 1) : en);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd,
                         input logic ack, input logic [DATA_W-1:0] rd);
    @(posedge mclk_i);
    {reg_wr_i, reg_rd_i, reg_idx_i, reg_wdata_i} <= {wr, ~wr, idx, wd};
    @(posedge mclk_i);
    {reg_wr_i, reg_rd_i} <= 2'h0;
    #1;
    chk(reg_ack_o, ack, "register ack");
    if (!wr && ack) chk(reg_rdata_o, rd, "register read");
  endtask
  // Exact address, address with its low bit flipped, and exact address without valid.
  task automatic probe(input int bi, input int bp, input int ofs, input int ign);
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk_i);
      i2c_addr_i       <= ADDR_W'((ign ? bi : bi + ofs) ^ (m == 1));
      pmbus_addr_i     <= ADDR_W'((ign ? bp : bp + ofs) ^ (m == 1));
      i2c_addr_vld_i   <= (m != 2);
      pmbus_addr_vld_i <= (m != 2);
      #1;
      chk(i2c_match_o, 16'((m == 0) && (bi != 0)), "i2c match");
      chk(pmbus_match_o, 16'((m == 0) && (bp != 0)), "pmbus match");
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Start-up scenarios
  // ----------------------------------------
  task automatic startup(input int k);
    int n;
    int ofs;
    int ctl;
    int en;
    seed = lfsr(seed);
    en   = (k % 2 == 0);
    @(posedge mclk_i);
    words[0]   <= (k == 2) ? 8'h00 : (k < 2) ? 8'h10 : seed[7:0];
    words[1]   <= (k == 3) ? 8'h00 : (k < 2) ? 8'h40 : seed[15:8];
    words[2]   <= (k == 4) ? 8'h01 : (k < 2) ? 8'h00 : seed[23:16];
    strap_code <= (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : (k == 5) ? 10'h2CF : (k == 6) ? 10'h2D0 : seed[31:22];
    lat        <= (k == 0) ? 4'hF : seed[27:24];
    {enable_ok_i, input_bus_ok_i} <= {2{en[0]}};
    {bias_ok_i, core_supply_rail_ok_i, osc_stable_i} <= 3'h7 & ~(3'h1 << (k % 3));
    repeat (3) @(posedge mclk_i);
    #1;
    chk(por_o, 1'b1, "por with a supply low");
    chk(store_rd_o, 1'b0, "load during por");
    @(posedge mclk_i);
    {bias_ok_i, core_supply_rail_ok_i, osc_stable_i} <= 3'h7;
    if (k < 2) reg_acc(k == 0, REG_I2C_BASE, 8'h00, 1'b0, 8'h00);
    n = 0;
    while (addr_ready_o !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1;
      chk(convert_en_o, 1'b0, "conversion before address");
      n++;
    end
    chk(config_loaded_o, 1'b1, "load done");
    ofs = ref_ofs(strap_code);
    ctl = words[2] & 8'h0F;
    reg_acc(1'b0, REG_I2C_BASE, 8'h00, 1'b1, {1'b0, words[0][6:0]});
    reg_acc(1'b0, REG_PMBUS_BASE, 8'h00, 1'b1, {1'b0, words[1][6:0]});
    reg_acc(1'b0, REG_CTRL, 8'h00, 1'b1, DATA_W'(ctl));
    reg_acc(1'b1, REG_STATUS, 8'hFF, 1'b1, 8'h00);
    reg_acc(1'b0, REG_STATUS, 8'h00, 1'b1, DATA_W'(ofs * 16 + ref_conv(ctl, en, en) * 4 + 3));
    probe(words[0][6:0], words[1][6:0], ofs, ctl & 1);
    reg_acc(1'b1, REG_I2C_BASE, seed[7:0] ^ 8'h5A, 1'b1, 8'h00);
    reg_acc(1'b0, REG_I2C_BASE, 8'h00, 1'b1, {1'b0, seed[6:0] ^ 7'h5A});
    probe(words[0][6:0], words[1][6:0], ofs, ctl & 1);
    if (k == 0) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge mclk_i);
        enable_ok_i <= c[3];
        reg_acc(1'b1, REG_CTRL, DATA_W'(c[2:0] * 2), 1'b1, 8'h00);
        reg_acc(1'b0, REG_CTRL, 8'h00, 1'b1, DATA_W'(c[2:0] * 2));
        chk(convert_en_o, 16'(ref_conv(c * 2 & 14, c[3], 1)), "conversion gate");
      end
      @(posedge mclk_i);
      input_bus_ok_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk(convert_en_o, 1'b0, "conversion with input bus low");
    end
  endtask

  initial begin
    // Supplies start low, so no load is cut short by the first scenario dropping a rail.
    {sys_rst_i, bias_ok_i, core_supply_rail_ok_i, osc_stable_i} = 4'h8;
    {enable_ok_i, input_bus_ok_i, reg_wr_i, reg_rd_i, i2c_addr_vld_i, pmbus_addr_vld_i} = 6'h00;
    {reg_idx_i, reg_wdata_i, i2c_addr_i, pmbus_addr_i, strap_code, lat} = '0;
    words = '0;
    seed  = 32'h1C50;
    @(posedge mclk_i);
    #1;
    chk(por_o, 1'b1, "por during reset");
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) startup(k);
    results();
  end
  // The whole run needs under a thousand cycles; this ceiling only catches a hang.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    results();
  end
endmodule
